// ### design/ram_block_pkg.sv
// Constants and types for the configurable embedded RAM block.
// Assumes a single fabric clock; shared by the block and its bench.
package ram_block_pkg;

    // ------------------------------------------------------------
    // Variants and port modes
    // ------------------------------------------------------------
    typedef enum {SMALL_RAM_BLOCK, MEDIUM_RAM_BLOCK, LARGE_RAM_BLOCK} variant_t;
    typedef enum {TRUE_DUAL_PORT, SIMPLE_DUAL_PORT, SINGLE_PORT} port_mode_t;

    // ------------------------------------------------------------
    // Native capacities
    // ------------------------------------------------------------
    localparam int SMALL_WORDS  = 32;
    localparam int SMALL_BITS   = 18;
    localparam int MEDIUM_WORDS = 128;
    localparam int MEDIUM_BITS  = 36;
    localparam int LARGE_WORDS  = 4096;
    localparam int LARGE_BITS   = 144;

    function automatic int ramWords(variant_t v);
        unique case (v)
            SMALL_RAM_BLOCK:  ramWords = SMALL_WORDS;
            MEDIUM_RAM_BLOCK: ramWords = MEDIUM_WORDS;
            LARGE_RAM_BLOCK:  ramWords = LARGE_WORDS;
        endcase
    endfunction

    function automatic int ramBits(variant_t v);
        unique case (v)
            SMALL_RAM_BLOCK:  ramBits = SMALL_BITS;
            MEDIUM_RAM_BLOCK: ramBits = MEDIUM_BITS;
            LARGE_RAM_BLOCK:  ramBits = LARGE_BITS;
        endcase
    endfunction

    // Only the large variant keeps its input registers through a clear
    function automatic bit clearsInputs(variant_t v);
        clearsInputs = (v != LARGE_RAM_BLOCK);
    endfunction

endpackage

// ### design/embedded_ram_block.sv
// Configurable synchronous RAM block with two ports on one clock.
// Assumes user logic presents inputs before the edge and honours the mode.
`timescale 1ns/10ps

module embedded_ram_block
    import ram_block_pkg::*;
#(
    parameter variant_t   VARIANT      = MEDIUM_RAM_BLOCK,
    parameter port_mode_t MODE         = TRUE_DUAL_PORT,
    parameter bit         OUT_REG      = 1'b0,
    parameter bit         PRELOAD      = 1'b0,
    localparam int        WORDS        = ramWords(VARIANT),
    localparam int        DW           = ramBits(VARIANT),
    localparam int        AW           = $clog2(WORDS),
    parameter logic [DW-1:0] PRELOAD_WORD = '0
) (
    input  wire logic          clk,      // Fabric clock
    input  wire logic          sys_rst,  // Synchronous reset, high
    input  wire logic          clr,      // Register clear, high
    input  wire logic [AW-1:0] addrA,    // Port A address
    input  wire logic [DW-1:0] dataA,    // Port A write data
    input  wire logic          weA,      // Port A write enable
    input  wire logic          reA,      // Port A read enable
    output logic      [DW-1:0] qA,       // Port A read data
    input  wire logic [AW-1:0] addrB,    // Port B address
    input  wire logic [DW-1:0] dataB,    // Port B write data
    input  wire logic          weB,      // Port B write enable
    input  wire logic          reB,      // Port B read enable
    output logic      [DW-1:0] qB        // Port B read data
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (VARIANT == SMALL_RAM_BLOCK && MODE == TRUE_DUAL_PORT) begin : gChkTdp
        $error("small variant has no true dual-port mode");
    end
    if (VARIANT == LARGE_RAM_BLOCK && PRELOAD) begin : gChkInit
        $error("large variant cannot be preloaded");
    end

    localparam bit CLR_INPUTS = clearsInputs(VARIANT);

    // ------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------
    logic [AW-1:0] addrA_q, addrB_q;
    logic [DW-1:0] dataA_q, dataB_q;
    logic          weA_q, weB_q, reA_q, reB_q;

    // Large variant keeps inputs through clr; sys_rst still clears all
    always_ff @(posedge clk) begin
        if (sys_rst || (clr && CLR_INPUTS)) begin
            addrA_q <= '0;
            dataA_q <= '0;
            weA_q   <= 1'b0;
            reA_q   <= 1'b0;
        end else begin
            addrA_q <= addrA;
            dataA_q <= dataA;
            weA_q   <= weA;
            reA_q   <= reA;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || (clr && CLR_INPUTS)) begin
            addrB_q <= '0;
            dataB_q <= '0;
            weB_q   <= 1'b0;
            reB_q   <= 1'b0;
        end else begin
            addrB_q <= addrB;
            dataB_q <= dataB;
            weB_q   <= weB;
            reB_q   <= reB;
        end
    end

    // ------------------------------------------------------------
    // Port roles per mode
    // ------------------------------------------------------------
    // Simple dual: A writes, B reads. Single: only port A is used.
    logic wrEnA, wrEnB, rdEnA, rdEnB;
    assign wrEnA = weA_q;
    assign wrEnB = weB_q && (MODE == TRUE_DUAL_PORT);
    assign rdEnA = reA_q && (MODE != SIMPLE_DUAL_PORT);
    assign rdEnB = reB_q && (MODE != SINGLE_PORT);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // No reset on the array; large variant always starts from zero here
    logic [DW-1:0] mem [WORDS] = '{default: (PRELOAD ? PRELOAD_WORD : '0)};

    // Same-address double write: port B lands last and wins.
    // Write enables held low after a one-time fill make a ROM.
    always_ff @(posedge clk) begin
        if (wrEnA) begin
            mem[addrA_q] <= dataA_q;
        end
        if (wrEnB) begin
            mem[addrB_q] <= dataB_q;
        end
    end

    logic [DW-1:0] oldWordA, oldWordB;
    assign oldWordA = mem[addrA_q];
    assign oldWordB = mem[addrB_q];

    // ------------------------------------------------------------
    // Read latches and output registers
    // ------------------------------------------------------------
    logic [DW-1:0] rdA_q, rdB_q, outA_q, outB_q;

    always_ff @(posedge clk) begin
        if (sys_rst || clr) begin
            rdA_q <= '0;
        end else if (MODE == SINGLE_PORT && wrEnA) begin
            rdA_q <= dataA_q;
        end else if (rdEnA) begin
            rdA_q <= oldWordA;
        end
    end

    // Mixed-port collision returns the word from before the write
    always_ff @(posedge clk) begin
        if (sys_rst || clr) begin
            rdB_q <= '0;
        end else if (rdEnB) begin
            rdB_q <= oldWordB;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || clr) begin
            outA_q <= '0;
            outB_q <= '0;
        end else begin
            outA_q <= rdA_q;
            outB_q <= rdB_q;
        end
    end

    if (OUT_REG) begin : gOutReg
        assign qA = outA_q;
        assign qB = outB_q;
    end else begin : gFlow
        assign qA = rdA_q;
        assign qB = rdB_q;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_SP_WRITE_SHOWS: assert property (@(posedge clk) disable iff (sys_rst)
        (MODE == SINGLE_PORT && weA && !clr) ##1 !clr |=> rdA_q == $past(dataA, 2))
        else $error("single-port write data not on read latch");

    AST_OUT_PIPE: assert property (@(posedge clk) disable iff (sys_rst)
        !clr |=> outA_q == $past(rdA_q) && outB_q == $past(rdB_q))
        else $error("output register does not follow read latch");

    AST_CLR_OUTPUTS: assert property (@(posedge clk) disable iff (sys_rst)
        clr |=> rdA_q == '0 && rdB_q == '0 && outA_q == '0 && outB_q == '0)
        else $error("clear left output registers set");

    AST_CLR_INPUTS: assert property (@(posedge clk) disable iff (sys_rst)
        clr |=> (CLR_INPUTS ? (addrA_q == '0 && !weA_q && !weB_q)
                            : (addrA_q == $past(addrA) && weA_q == $past(weA))))
        else $error("input register clear behaviour wrong for variant");

    AST_SDP_OLD_DATA: assert property (@(posedge clk) disable iff (sys_rst)
        (MODE == SIMPLE_DUAL_PORT && wrEnA && rdEnB && addrA_q == addrB_q && !clr)
        |=> rdB_q == $past(oldWordB) && rdB_q != $past(dataA_q) || $past(oldWordB == dataA_q))
        else $error("collision read did not return old word");

    AST_TDP_TWO_WRITES: assert property (@(posedge clk) disable iff (sys_rst)
        (MODE == TRUE_DUAL_PORT && wrEnA && wrEnB && addrA_q != addrB_q)
        |=> mem[$past(addrA_q)] == $past(dataA_q) && mem[$past(addrB_q)] == $past(dataB_q))
        else $error("simultaneous writes not both stored");

    AST_NO_TDP_SMALL: assert property (@(posedge clk) disable iff (sys_rst)
        VARIANT == SMALL_RAM_BLOCK |-> !wrEnB)
        else $error("small variant wrote through second port");

    AST_READ_RETURNS: assert property (@(posedge clk) disable iff (sys_rst)
        (rdEnA && !wrEnA && !wrEnB && !clr) |=> rdA_q == $past(oldWordA))
        else $error("port A read did not return stored word");

endmodule // embedded_ram_block

// ### bench/fabric_port_model.sv
// Fabric-side user logic behind port B of the RAM block.
// Assumes requests change on the rising edge; drives the port at the falling edge.
`timescale 1ns/10ps

module fabric_port_model #(
    parameter int AW = 7,
    parameter int DW = 36
) (
    input  wire logic          clk,      // Fabric clock
    input  wire logic          rqWe,     // Write request
    input  wire logic          rqRe,     // Read request
    input  wire logic [AW-1:0] rqAddr,   // Request address
    input  wire logic [DW-1:0] rqData,   // Request data
    output logic               weB,      // Port write enable
    output logic               reB,      // Port read enable
    output logic      [AW-1:0] addrB,    // Port address
    output logic      [DW-1:0] dataB     // Port write data
);
    // Idle data toggles so a stale word is never mistaken for a write
    initial begin
        weB   = 1'b0;
        reB   = 1'b0;
        addrB = '0;
        dataB = '0;
    end
    always @(negedge clk) begin
        weB   <= rqWe;
        reB   <= rqRe;
        addrB <= rqAddr;
        dataB <= rqWe ? rqData : ~dataB;
    end
endmodule // fabric_port_model

// ### bench/embedded_ram_block_tb.sv
// Self-checking bench for the medium RAM block in all three port modes.
// Assumes unregistered outputs except on the single-port instance, and an array that starts at zero.
`timescale 1ns/10ps

module embedded_ram_block_tb;
    import ram_block_pkg::*;
    localparam int AW = 7;
    localparam int DW = 36;
    logic clk, rst, clr, weA, reA, rqWe, rqRe, weB, reB;
    logic [AW-1:0] addrA, rqAddr, addrB;
    logic [DW-1:0] dataA, rqData, dataB, qA, qB;
    logic [DW-1:0] qSdpA, qSdpB, qSpA, qSpB;
    int n_mismatch = 0;
    int compares = 0;

    embedded_ram_block #(.VARIANT(MEDIUM_RAM_BLOCK), .MODE(TRUE_DUAL_PORT)) uut (
        .clk(clk), .sys_rst(rst), .clr(clr), .addrA(addrA), .dataA(dataA), .weA(weA),
        .reA(reA), .qA(qA), .addrB(addrB), .dataB(dataB), .weB(weB), .reB(reB), .qB(qB));
    fabric_port_model #(.AW(AW), .DW(DW)) partner (
        .clk(clk), .rqWe(rqWe), .rqRe(rqRe), .rqAddr(rqAddr), .rqData(rqData),
        .weB(weB), .reB(reB), .addrB(addrB), .dataB(dataB));
    // Same stimulus into the other two modes; their refused ports see it too
    embedded_ram_block #(.VARIANT(MEDIUM_RAM_BLOCK), .MODE(SIMPLE_DUAL_PORT)) uutSdp (
        .clk(clk), .sys_rst(rst), .clr(clr), .addrA(addrA), .dataA(dataA), .weA(weA),
        .reA(reA), .qA(qSdpA), .addrB(addrB), .dataB(dataB), .weB(weB), .reB(reB),
        .qB(qSdpB));
    embedded_ram_block #(.VARIANT(MEDIUM_RAM_BLOCK), .MODE(SINGLE_PORT), .OUT_REG(1'b1)) uutSp (
        .clk(clk), .sys_rst(rst), .clr(clr), .addrA(addrA), .dataA(dataA), .weA(weA),
        .reA(reA), .qA(qSpA), .addrB(addrB), .dataB(dataB), .weB(weB), .reB(reB),
        .qB(qSpB));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t read data %h expected %h", $time, got, exp);
        end
    endtask

    // One access on each port in the same cycle, then idle until q settles
    task automatic op(input logic wa, ra, input logic [AW-1:0] aa, input logic [DW-1:0] da,
                      input logic wb, rb, input logic [AW-1:0] ab, input logic [DW-1:0] db);
        @(posedge clk);
        {rqWe, rqRe, rqAddr, rqData} = {wb, rb, ab, db};
        @(negedge clk);
        {weA, reA, addrA, dataA} = {wa, ra, aa, da};
        @(posedge clk);
        {rqWe, rqRe} = 2'b00;
        @(negedge clk);
        {weA, reA, clr} = 3'b000;
        dataA = ~dataA;
        repeat (2) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testDualWriteRead();
        op(1'b1, 1'b0, 7'h00, 36'hA5A5A5A5A, 1'b1, 1'b0, 7'h7F, 36'h123456789);
        op(1'b0, 1'b1, 7'h7F, '0, 1'b0, 1'b1, 7'h00, '0);
        chk(qA, 36'h123456789);
        chk(qB, 36'hA5A5A5A5A);
        op(1'b0, 1'b1, 7'h00, '0, 1'b1, 1'b0, 7'h01, 36'hFEDCBA987);
        chk(qA, 36'hA5A5A5A5A);
        chk(qB, 36'hA5A5A5A5A);
        op(1'b0, 1'b1, 7'h01, '0, 1'b0, 1'b0, 7'h00, '0);
        chk(qA, 36'hFEDCBA987);
    endtask

    // Clear drops the pending write on this size and zeroes the read data
    task automatic testClear();
        clr = 1'b1;
        op(1'b1, 1'b0, 7'h09, 36'hCAFE0BEEF, 1'b0, 1'b0, 7'h00, '0);
        chk(qA, '0);
        chk(qB, '0);
        op(1'b0, 1'b1, 7'h09, '0, 1'b0, 1'b1, 7'h7F, '0);
        chk(qA, '0);
        chk(qB, 36'h123456789);
    endtask

    // Only address 00 was written through port A before this point
    task automatic testModes();
        op(1'b1, 1'b0, 7'h10, 36'h111111111, 1'b0, 1'b1, 7'h10, '0);
        chk(qSdpB, '0);
        chk(qB, '0);
        chk(qSpA, 36'h111111111);
        op(1'b0, 1'b1, 7'h00, '0, 1'b0, 1'b1, 7'h10, '0);
        chk(qSdpB, 36'h111111111);
        chk(qSdpA, '0);
        chk(qSpA, 36'hA5A5A5A5A);
        chk(qSpB, '0);
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {rst, clr, weA, reA, rqWe, rqRe} = 6'b100000;
        {addrA, rqAddr, dataA, rqData} = '0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk(qA, '0);
        chk(qB, '0);
        testDualWriteRead();
        testClear();
        testModes();
        end_of_test();
    end
endmodule // embedded_ram_block_tb
